// File: sbp_map.svh
// Register offsets, field positions, reset values and fixed codes of the configuration block.
`ifndef SBP_MAP_SVH
`define SBP_MAP_SVH

// Printed register indices; the APB byte address is four times the index.
`define SBP_IDX_DIAG_CFG      8'h24
`define SBP_IDX_LINK_OPT      8'h25
`define SBP_ADDR_DIAG_CFG     12'h090
`define SBP_ADDR_LINK_OPT     12'h094

// Background diagnostic configuration fields.
`define SBP_DIAG_EN_BIT       0
`define SBP_DIAG_FRAG_BIT     1
`define SBP_DIAG_CFG_RESET    8'h00

// Serial link option byte fields.
`define SBP_OPT_PULLDOWN_BIT  7
`define SBP_OPT_CHAIN_BIT     6
`define SBP_OPT_LOWCUR_BIT    5
`define SBP_OPT_RANGE_BIT     4
`define SBP_OPT_ERRC_BIT      3
`define SBP_OPT_CRC_BIT       2
`define SBP_OPT_PH2_BIT       1
`define SBP_OPT_FREE_BIT      0
`define SBP_LINK_OPT_RESET    8'h00

// Fragment sizes per collection period.
`define SBP_FRAG_CMD_SMALL    3'h2
`define SBP_FRAG_RSP_SMALL    3'h3
`define SBP_FRAG_CMD_LARGE    3'h4
`define SBP_FRAG_RSP_LARGE    3'h6

// Relative pressure clip limits and the common and base error codes.
`define SBP_CLIP_LO_NORM      (-16'sd102)
`define SBP_CLIP_HI_NORM      (16'sd307)
`define SBP_CLIP_LO_EXT       (-16'sd480)
`define SBP_CLIP_HI_EXT       (16'sd480)
`define SBP_ERR_CODE_COMMON   10'h1f4
`define SBP_ERR_CODE_BASE     10'h1f5

`endif

// File: sbp_pkg.sv
// Types shared by the configuration block.
package sbp_pkg;

   typedef enum logic [1:0]
   {
      SBP_IDLE = 2'b00,
      SBP_WAIT = 2'b01,
      SBP_DONE = 2'b11
   } sbp_bus_state_t;

   typedef struct packed
   {
      sbp_bus_state_t   busState;
      logic             loadPending;
      logic [7:0]       diagCfg;
      logic [7:0]       linkOpt;
      logic             checkBit;
      logic             checkError;
      logic [31:0]      prdata;
      logic             pslverr;
      logic             pready;
      logic             diagEnable;
      logic [2:0]       diagCmdBits;
      logic [2:0]       diagRspChips;
      logic             syncPulldown;
      logic             chainMode;
      logic             lowCurrent;
      logic             crcSelect;
      logic             phase2Extend;
      logic             freeRunning;
      logic [9:0]       txPressure;
      logic [9:0]       errorCode;
   } sbp_state_t;

endpackage : sbp_pkg

// File: sbp_config.sv
// APB register bank holding background diagnostic and serial link option settings.
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "sbp_map.svh"

module sbp_config
(
   // Clock and reset.
   input  wire logic                clock,
   input  wire logic                srst,
   // APB slave.
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic                     pready,
   output logic [31:0]              prdata,
   output logic                     pslverr,
   // Operating mode and OTP contents.
   input  wire logic                modePsi5,
   input  wire logic                modeDiag,
   input  wire logic                otpProgrammed,
   input  wire logic [7:0]          otpLinkOpt,
   // Link events and data.
   input  wire logic                syncPulseSeen,
   input  wire logic                syncPulseOver,
   input  wire logic signed [15:0]  relPressure,
   input  wire logic                internalError,
   input  wire logic [3:0]          internalErrorId,
   // Configuration outputs.
   output logic                     diagEnable,
   output logic [2:0]               diagCmdBits,
   output logic [2:0]               diagRspChips,
   output logic                     syncPulldown,
   output logic                     chainMode,
   output logic                     lowCurrent,
   output logic                     crcSelect,
   output logic                     phase2Extend,
   output logic                     freeRunning,
   output logic [9:0]               txPressure,
   output logic [9:0]               errorCode,
   output logic                     checkError
);

   sbp_pkg::sbp_state_t state;
   sbp_pkg::sbp_state_t next_state;

   logic                accessOk;
   logic                hitDiag;
   logic                hitOpt;
   logic                commit;
   logic signed [15:0]  clipLo;
   logic signed [15:0]  clipHi;
   logic signed [15:0]  clipped;

   // Even parity over both bytes, used as the array check signature.
   function automatic logic array_parity
   (
      input logic [7:0] diag,
      input logic [7:0] opt
   );
      array_parity = ^{diag, opt};
   endfunction : array_parity

   // Full address decode: a register answers only at its own byte address.
   function automatic logic addr_hit
   (
      input logic [11:0] addr,
      input logic [11:0] target
   );
      addr_hit = (addr == target);
   endfunction : addr_hit

   // Option bits act only under PSI5; under DSI3 they are stored but ignored.
   function automatic logic psi5_bit
   (
      input logic psi5,
      input logic optBit
   );
      psi5_bit = psi5 && optBit;
   endfunction : psi5_bit

   always_comb
   begin
      next_state = state;
      hitDiag = addr_hit(paddr, `SBP_ADDR_DIAG_CFG);
      hitOpt = addr_hit(paddr, `SBP_ADDR_LINK_OPT);
      accessOk = !modePsi5 || modeDiag;
      commit = psel && penable && state.pready;
      clipLo = `SBP_CLIP_LO_NORM;
      clipHi = `SBP_CLIP_HI_NORM;
      clipped = relPressure;

      // Bus handshake: one wait state, then pready for exactly one cycle.
      case (state.busState)
         sbp_pkg::SBP_IDLE:
         begin
            next_state.pready = 1'b0;
            if (psel && !penable)
            begin
               next_state.busState = sbp_pkg::SBP_WAIT;
            end
         end
         sbp_pkg::SBP_WAIT:
         begin
            if (psel && penable)
            begin
               next_state.busState = sbp_pkg::SBP_DONE;
               next_state.pready = 1'b1;
               next_state.pslverr = 1'b0;
               next_state.prdata = 32'h0000_0000;
               if (!accessOk)
               begin
                  next_state.pslverr = 1'b1;
               end
               else if (hitDiag)
               begin
                  next_state.prdata = {24'h00_0000, state.diagCfg};
               end
               else if (hitOpt)
               begin
                  next_state.prdata = {24'h00_0000, state.linkOpt};
               end
               else
               begin
                  next_state.pslverr = 1'b1;
               end
            end
         end
         sbp_pkg::SBP_DONE:
         begin
            next_state.busState = sbp_pkg::SBP_IDLE;
            next_state.pready = 1'b0;
            next_state.pslverr = 1'b0;
            next_state.prdata = 32'h0000_0000;
            if (psel && !penable)
            begin
               next_state.busState = sbp_pkg::SBP_WAIT;
            end
         end
         default:
         begin
            next_state.busState = sbp_pkg::SBP_IDLE;
            next_state.pready = 1'b0;
         end
      endcase

      // Writes take effect only at the edge where the master sees pready.
      if (commit && pwrite && !state.pslverr)
      begin
         if (hitDiag)
         begin
            next_state.diagCfg = pwdata[7:0];
         end
         else if (hitOpt)
         begin
            next_state.linkOpt = pwdata[7:0];
         end
      end

      // The OTP image is copied one cycle after reset release, never under reset.
      if (state.loadPending)
      begin
         next_state.loadPending = 1'b0;
         next_state.linkOpt = otpProgrammed ? otpLinkOpt : `SBP_LINK_OPT_RESET;
      end

      // The signature follows every legal update; a mismatch means upset storage.
      next_state.checkBit = array_parity(next_state.diagCfg, next_state.linkOpt);
      next_state.checkError = (array_parity(state.diagCfg, state.linkOpt) != state.checkBit);

      // Background diagnostics act only under DSI3.
      next_state.diagEnable = !modePsi5 && state.diagCfg[`SBP_DIAG_EN_BIT];
      if (modePsi5)
      begin
         next_state.diagCmdBits = 3'h0;
         next_state.diagRspChips = 3'h0;
      end
      else if (state.diagCfg[`SBP_DIAG_FRAG_BIT])
      begin
         next_state.diagCmdBits = `SBP_FRAG_CMD_LARGE;
         next_state.diagRspChips = `SBP_FRAG_RSP_LARGE;
      end
      else
      begin
         next_state.diagCmdBits = `SBP_FRAG_CMD_SMALL;
         next_state.diagRspChips = `SBP_FRAG_RSP_SMALL;
      end

      // Pulldown arms on a detected sync pulse and drops at the end of it.
      if (!psi5_bit(modePsi5, state.linkOpt[`SBP_OPT_PULLDOWN_BIT]))
      begin
         next_state.syncPulldown = 1'b0;
      end
      else if (syncPulseSeen)
      begin
         next_state.syncPulldown = 1'b1;
      end
      else if (syncPulseOver)
      begin
         next_state.syncPulldown = 1'b0;
      end

      next_state.chainMode = psi5_bit(modePsi5, state.linkOpt[`SBP_OPT_CHAIN_BIT]);
      next_state.lowCurrent = psi5_bit(modePsi5, state.linkOpt[`SBP_OPT_LOWCUR_BIT]);
      next_state.crcSelect = psi5_bit(modePsi5, state.linkOpt[`SBP_OPT_CRC_BIT]);
      next_state.phase2Extend = psi5_bit(modePsi5, state.linkOpt[`SBP_OPT_PH2_BIT]);
      next_state.freeRunning = psi5_bit(modePsi5, state.linkOpt[`SBP_OPT_FREE_BIT])
                               && !state.linkOpt[`SBP_OPT_CHAIN_BIT];

      // Clipping widens only with the range bit under PSI5.
      if (psi5_bit(modePsi5, state.linkOpt[`SBP_OPT_RANGE_BIT]))
      begin
         clipLo = `SBP_CLIP_LO_EXT;
         clipHi = `SBP_CLIP_HI_EXT;
      end
      if (relPressure < clipLo)
      begin
         clipped = clipLo;
      end
      else if (relPressure > clipHi)
      begin
         clipped = clipHi;
      end
      next_state.txPressure = clipped[9:0];

      // Without the extension every internal error shares one code.
      if (!internalError)
      begin
         next_state.errorCode = 10'h000;
      end
      else if (psi5_bit(modePsi5, state.linkOpt[`SBP_OPT_ERRC_BIT]))
      begin
         next_state.errorCode = `SBP_ERR_CODE_BASE + {6'h00, internalErrorId};
      end
      else
      begin
         next_state.errorCode = `SBP_ERR_CODE_COMMON;
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         // Each field is reset by name, so no field is written twice at one edge.
         state.busState <= sbp_pkg::SBP_IDLE;
         state.loadPending <= 1'b1;
         state.diagCfg <= `SBP_DIAG_CFG_RESET;
         state.linkOpt <= `SBP_LINK_OPT_RESET;
         state.checkBit <= 1'b0;
         state.checkError <= 1'b0;
         state.prdata <= 32'h0000_0000;
         state.pslverr <= 1'b0;
         state.pready <= 1'b0;
         state.diagEnable <= 1'b0;
         state.diagCmdBits <= 3'h0;
         state.diagRspChips <= 3'h0;
         state.syncPulldown <= 1'b0;
         state.chainMode <= 1'b0;
         state.lowCurrent <= 1'b0;
         state.crcSelect <= 1'b0;
         state.phase2Extend <= 1'b0;
         state.freeRunning <= 1'b0;
         state.txPressure <= 10'h000;
         state.errorCode <= 10'h000;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign pready = state.pready;
   assign prdata = state.prdata;
   assign pslverr = state.pslverr;
   assign diagEnable = state.diagEnable;
   assign diagCmdBits = state.diagCmdBits;
   assign diagRspChips = state.diagRspChips;
   assign syncPulldown = state.syncPulldown;
   assign chainMode = state.chainMode;
   assign lowCurrent = state.lowCurrent;
   assign crcSelect = state.crcSelect;
   assign phase2Extend = state.phase2Extend;
   assign freeRunning = state.freeRunning;
   assign txPressure = state.txPressure;
   assign errorCode = state.errorCode;
   assign checkError = state.checkError;

endmodule : sbp_config
`default_nettype wire

// File: sbp_link_model.sv
// Far-side link model that produces one sync pulse per kick.
`timescale 1ns/10ps
`default_nettype none
module sbp_link_model
(
   // Clock and trigger.
   input  wire logic clock,
   input  wire logic kick,
   // Sync pulse events.
   output logic      syncPulseSeen,
   output logic      syncPulseOver
);
   logic [2:0] span = 3'h0;
   // The pulse lasts four cycles, so its end arrives well after its start.
   assign syncPulseSeen = (span == 3'h5);
   assign syncPulseOver = (span == 3'h1);
   always_ff @(posedge clock)
   begin
      span <= kick ? 3'h5 : ((span != 3'h0) ? span - 3'h1 : 3'h0);
   end
endmodule : sbp_link_model
`default_nettype wire

// File: sbp_config_asserts.sv
// Concurrent checks on the configuration block ports.
`timescale 1ns/10ps
`default_nettype none
module sbp_config_asserts
(
   // Clock, reset and bus.
   input  wire logic       clock,
   input  wire logic       srst,
   input  wire logic       psel,
   input  wire logic       penable,
   input  wire logic       pready,
   input  wire logic       pslverr,
   // Modes and events.
   input  wire logic       modePsi5,
   input  wire logic       modeDiag,
   input  wire logic       syncPulseSeen,
   // Settings.
   input  wire logic       diagEnable,
   input  wire logic [2:0] diagCmdBits,
   input  wire logic [2:0] diagRspChips,
   input  wire logic       syncPulldown,
   input  wire logic       chainMode,
   input  wire logic       crcSelect,
   input  wire logic       phase2Extend,
   input  wire logic       freeRunning,
   input  wire logic [9:0] txPressure,
   input  wire logic       checkError
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   frag_small_a: assert property (diagCmdBits == 3'h2 |-> diagRspChips == 3'h3)
      else $error("small fragment wrong");
   frag_large_a: assert property (diagCmdBits == 3'h4 |-> diagRspChips == 3'h6)
      else $error("large fragment wrong");
   psi5_diag_quiet_a: assert property (!$past(srst) && $past(modePsi5)
      |-> !diagEnable && diagCmdBits == 3'h0) else $error("diag active in psi5");
   dsi3_opt_quiet_a: assert property (!$past(srst) && !$past(modePsi5)
      |-> !(crcSelect | phase2Extend | freeRunning)) else $error("option active in dsi3");
   free_chain_a: assert property (freeRunning |-> !chainMode)
      else $error("free running in chain");
   pulldown_cause_a: assert property ($rose(syncPulldown) |-> $past(syncPulseSeen))
      else $error("pulldown without sync");
   clip_range_a: assert property ($signed(txPressure) >= -10'sd480
      && $signed(txPressure) <= 10'sd480) else $error("pressure out of range");
   access_refused_a: assert property (pready && $past(modePsi5) && !$past(modeDiag)
      |-> pslverr) else $error("psi5 access accepted");
   bus_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("bus answer timing");
   reset_zero_a: assert property ($past(srst) |-> !pready && !diagEnable)
      else $error("output set after reset");
   storage_check_a: assert property (!checkError)
      else $error("storage check failed");
   cover property (pready && pslverr);
   cover property (pready && modePsi5 && !pslverr);
   cover property ($rose(syncPulldown));
endmodule : sbp_config_asserts
bind sbp_config sbp_config_asserts i_chk (.clock, .srst, .psel, .penable, .pready,
   .pslverr, .modePsi5, .modeDiag, .syncPulseSeen, .diagEnable, .diagCmdBits,
   .diagRspChips, .syncPulldown, .chainMode, .crcSelect, .phase2Extend, .freeRunning,
   .txPressure, .checkError);
`default_nettype wire

// File: sbp_config_bench.sv
// Self-checking bench for the configuration block.
`timescale 1ns/10ps
`default_nettype none
`include "sbp_map.svh"
module sbp_config_bench;
   logic               clock = 1'b0;
   logic               srst = 1'b1;
   logic               psel = 1'b0;
   logic               penable = 1'b0;
   logic               pwrite = 1'b0;
   logic [11:0]        paddr = 12'h000;
   logic [31:0]        pwdata = 32'h0;
   logic               modePsi5 = 1'b0;
   logic               modeDiag = 1'b0;
   logic               otpProgrammed = 1'b0;
   logic [7:0]         otpLinkOpt = 8'h00;
   logic signed [15:0] relPressure = 16'sh0;
   logic               internalError = 1'b0;
   logic [3:0]         internalErrorId = 4'h0;
   logic               kick = 1'b0;
   logic               pready, pslverr, rerr, syncPulseSeen, syncPulseOver;
   logic               diagEnable, syncPulldown, chainMode, lowCurrent, crcSelect;
   logic               phase2Extend, freeRunning, checkError;
   logic [2:0]         diagCmdBits, diagRspChips;
   logic [9:0]         txPressure, errorCode;
   logic [31:0]        prdata, rdata;
   logic [7:0]         m;
   int                 numErrors = 0;
   int                 checksDone = 0;
   int                 cycles = 0;
   logic signed [15:0] pin [4] = '{16'sd400, -16'sd200, 16'sd600, -16'sd600};
   logic [9:0]         pout [4] = '{10'h133, 10'h39a, 10'h1e0, 10'h220};
   sbp_config i_dut (.clock, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr, .modePsi5, .modeDiag, .otpProgrammed, .otpLinkOpt,
      .syncPulseSeen, .syncPulseOver, .relPressure, .internalError, .internalErrorId,
      .diagEnable, .diagCmdBits, .diagRspChips, .syncPulldown, .chainMode, .lowCurrent,
      .crcSelect, .phase2Extend, .freeRunning, .txPressure, .errorCode, .checkError);
   sbp_link_model i_link (.clock, .kick, .syncPulseSeen, .syncPulseOver);
   initial forever #2 clock = ~clock;
   task automatic stop_test();
      $display("errors %0d checks %0d", numErrors, checksDone);
      if (numErrors == 0 && checksDone > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   // A hung bus wait must still reach the verdict.
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         numErrors++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp)
      begin
         numErrors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask : cyc
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
      begin
         @(posedge clock);
      end
      while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d);
      chk({31'h0, rerr}, {31'h0, e});
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic e);
      apb(1'b0, a, 32'h0);
      chk(rdata, x);
      chk({31'h0, rerr}, {31'h0, e});
   endtask : rd
   task automatic rst(input logic p, input logic [7:0] v);
      srst <= 1'b1;
      otpProgrammed <= p;
      otpLinkOpt <= v;
      cyc(8);
      srst <= 1'b0;
      cyc(2);
   endtask : rst
   initial
   begin
      rst(1'b0, 8'ha5);
      rd(`SBP_ADDR_LINK_OPT, 32'h0, 1'b0);
      rd(`SBP_ADDR_DIAG_CFG, 32'h0, 1'b0);
      for (int i = 0; i < 4; i++)
      begin
         wr(`SBP_ADDR_DIAG_CFG, i, 1'b0);
         cyc(2);
         chk({diagEnable, diagCmdBits, diagRspChips}, {i[0], i[1] ? 6'h26 : 6'h13});
      end
      wr(`SBP_ADDR_LINK_OPT, 32'hff, 1'b0);
      cyc(2);
      chk({chainMode, lowCurrent, crcSelect, phase2Extend, freeRunning}, 32'h0);
      rd(`SBP_ADDR_LINK_OPT, 32'hff, 1'b0);
      modePsi5 <= 1'b1;
      modeDiag <= 1'b1;
      cyc(2);
      chk({diagEnable, diagCmdBits, diagRspChips}, 32'h0);
      rd(`SBP_ADDR_DIAG_CFG, 32'h3, 1'b0);
      for (int i = 0; i < 9; i++)
      begin
         m = (i < 8) ? (8'h01 << i) : 8'h41;
         wr(`SBP_ADDR_LINK_OPT, m, 1'b0);
         cyc(2);
         chk({chainMode, lowCurrent, crcSelect, phase2Extend, freeRunning},
            {m[6], m[5], m[2], m[1], m[0] & ~m[6]});
         rd(`SBP_ADDR_LINK_OPT, m, 1'b0);
      end
      for (int i = 0; i < 4; i++)
      begin
         wr(`SBP_ADDR_LINK_OPT, (i < 2) ? 32'h00 : 32'h10, 1'b0);
         relPressure <= pin[i];
         cyc(3);
         chk(txPressure, pout[i]);
      end
      internalErrorId <= 4'h3;
      internalError <= 1'b1;
      wr(`SBP_ADDR_LINK_OPT, 32'h00, 1'b0);
      cyc(2);
      chk(errorCode, 10'h1f4);
      wr(`SBP_ADDR_LINK_OPT, 32'h08, 1'b0);
      cyc(2);
      chk(errorCode, 10'h1f8);
      internalError <= 1'b0;
      cyc(2);
      chk(errorCode, 10'h000);
      for (int i = 0; i < 2; i++)
      begin
         wr(`SBP_ADDR_LINK_OPT, i ? 32'h00 : 32'h80, 1'b0);
         kick <= 1'b1;
         cyc(1);
         kick <= 1'b0;
         cyc(2);
         chk(syncPulldown, !i);
         cyc(5);
         chk(syncPulldown, 1'b0);
      end
      modeDiag <= 1'b0;
      cyc(2);
      wr(`SBP_ADDR_LINK_OPT, 32'h55, 1'b1);
      rd(`SBP_ADDR_LINK_OPT, 32'h0, 1'b1);
      modeDiag <= 1'b1;
      cyc(2);
      rd(`SBP_ADDR_LINK_OPT, 32'h0, 1'b0);
      rd(12'h0a0, 32'h0, 1'b1);
      rst(1'b1, 8'h5a);
      rd(`SBP_ADDR_LINK_OPT, 32'h5a, 1'b0);
      rd(`SBP_ADDR_DIAG_CFG, 32'h0, 1'b0);
      chk(checkError, 1'b0);
      stop_test();
   end
endmodule : sbp_config_bench
`default_nettype wire
